// File: rtl/slm_miss_counter.sv
// consecutive missed synchronisation interrupt counter
`timescale 1ns/1ps
module slm_miss_counter #(
  parameter int CNT_W = slm_pkg::SLM_MISS_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic active,
  input wire logic tick,
  input wire logic serviced,
  input wire logic [3:0] thresh,
  output logic [CNT_W-1:0] count,
  output logic over
);
  import slm_pkg::*;

  // counter must hold one more than the largest threshold
  if (CNT_W < 5)
  begin : g_cnt_w_check
    $error("slm_miss_counter: CNT_W must be at least 5");
  end

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  wire at_max = &cnt_r;

  // a service ends the run even if a slot also closes
  always_comb
  begin
    cnt_nxt = cnt_r;
    if (!active)
      cnt_nxt = '0;
    else if (serviced)
      cnt_nxt = '0;
    else if (tick && !at_max)
      cnt_nxt = cnt_r + 1'b1;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_r <= '0;
    else
      cnt_r <= cnt_nxt;
  end

  assign count = cnt_r;
  // strictly above threshold
  assign over = active && (cnt_r > CNT_W'(thresh));
endmodule : slm_miss_counter

// File: rtl/slm_monitor.sv
// sync loss error monitor: apb registers, error detection, state forcing, indicator
//
// Overview of operation
// - Phase-lock loss raises an error in SafeOP or OP, DC or SM2 only.
// - Any phase-lock error forces the state machine down to SafeOP.
// - Phase-lock error loads status code 0032h for the master to read.
// - Alarm clear removes the error; indicator single-flashes while it is active.
// - After sync done, misses above threshold raise sync error and SafeOP.
// - With op-only bit zero, sync errors are watched in SafeOP and OP.
// - With op-only bit one, sync errors are watched only in OP.
// - Sync signal errors are never flagged in free-run mode.
`timescale 1ns/1ps
module slm_monitor #(
  parameter int FLASH_ON_CYC = slm_pkg::SLM_FLASH_ON_CYC,
  parameter int FLASH_OFF_CYC = slm_pkg::SLM_FLASH_OFF_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic phase_lock_lost,
  input wire slm_pkg::slm_sync_type sync_in,
  output slm_pkg::slm_esm_type esm_state,
  output logic [15:0] al_status_code,
  output logic phase_lock_error_code,
  output logic sync_signal_error_code,
  output logic err_led,
  output logic irq
);
  import slm_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // elaboration checks

  if (FLASH_ON_CYC < 1 || FLASH_OFF_CYC < 1)
  begin : g_flash_min
    $error("slm_monitor: flash counts must be at least one cycle");
  end
  if (FLASH_ON_CYC > 268435455 || FLASH_OFF_CYC > 268435455)
  begin : g_flash_max
    $error("slm_monitor: flash counts exceed the timer width");
  end

  ////////////////////////////////////////////////////////////////////////////
  // helper functions

  // one-word decode shared by read and write paths
  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] ofs);
    reg_hit = (addr == ofs);
  endfunction : reg_hit

  // state to software code
  function automatic logic [1:0] esm_code(input slm_esm_type s);
    case (s)
      SLM_ST_INIT: esm_code = SLM_ESM_INIT;
      SLM_ST_PREOP: esm_code = SLM_ESM_PREOP;
      SLM_ST_SAFEOP: esm_code = SLM_ESM_SAFEOP;
      SLM_ST_OP: esm_code = SLM_ESM_OP;
      default: esm_code = SLM_ESM_INIT;
    endcase
  endfunction : esm_code

  // software code to state
  function automatic slm_esm_type esm_from(input logic [1:0] c);
    case (c)
      SLM_ESM_INIT: esm_from = SLM_ST_INIT;
      SLM_ESM_PREOP: esm_from = SLM_ST_PREOP;
      SLM_ESM_SAFEOP: esm_from = SLM_ST_SAFEOP;
      SLM_ESM_OP: esm_from = SLM_ST_OP;
      default: esm_from = SLM_ST_INIT;
    endcase
  endfunction : esm_from

  ////////////////////////////////////////////////////////////////////////////
  // apb decode

  wire setup = psel && !penable;
  wire access = psel && penable;
  wire wr = access && pwrite;
  wire hit_ctrl = reg_hit(paddr, SLM_OFS_CTRL);
  wire hit_thresh = reg_hit(paddr, SLM_OFS_THRESH);
  wire hit_status = reg_hit(paddr, SLM_OFS_STATUS);
  wire hit_alcode = reg_hit(paddr, SLM_OFS_ALCODE);
  wire hit_istat = reg_hit(paddr, SLM_OFS_IRQ_STAT);
  wire hit_imask = reg_hit(paddr, SLM_OFS_IRQ_MASK);
  wire hit_esm = reg_hit(paddr, SLM_OFS_ESM_REQ);
  wire hit_any = hit_ctrl | hit_thresh | hit_status | hit_alcode | hit_istat | hit_imask | hit_esm;

  // zero wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = access && !hit_any;

  wire wr_ctrl = wr && hit_ctrl;
  wire wr_thresh = wr && hit_thresh;
  wire wr_istat = wr && hit_istat;
  wire wr_imask = wr && hit_imask;
  wire wr_esm = wr && hit_esm;
  // clear bit is a write strobe, never stored
  wire alarm_clear = wr_ctrl && pwdata[SLM_CTRL_CLEAR_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers

  slm_cfg_type cfg_r;
  logic [3:0] thresh_r;
  logic [1:0] imask_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg_r <= '0;
      thresh_r <= SLM_THRESH_RST;
      imask_r <= SLM_IRQ_MASK_RST;
    end
    else
    begin
      if (wr_ctrl)
        cfg_r <= {pwdata[SLM_CTRL_OP_ONLY_BIT], pwdata[SLM_CTRL_MODE_LSB +: 2]};
      if (wr_thresh)
        thresh_r <= pwdata[3:0];
      if (wr_imask)
        imask_r <= pwdata[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // detection windows

  slm_esm_type esm_r;
  slm_esm_type esm_nxt;

  wire sync_mode = (cfg_r.mode == SLM_MODE_DC) || (cfg_r.mode == SLM_MODE_SM2);
  wire in_safeop = (esm_r == SLM_ST_SAFEOP);
  wire in_op = (esm_r == SLM_ST_OP);
  // phase lock watched in both upper states
  wire pll_window = sync_mode && (in_safeop || in_op);
  // op-only bit drops safeop from the sync window
  wire sync_state_ok = in_op || (in_safeop && !cfg_r.op_only);
  wire sync_window = sync_mode && sync_state_ok && sync_in.done;

  ////////////////////////////////////////////////////////////////////////////
  // missed interrupt counter

  logic [SLM_MISS_W-1:0] miss_count;
  logic miss_over;

  slm_miss_counter #(
    .CNT_W(SLM_MISS_W)
  ) u_miss (
    .clk(pclk),
    .rst_n(presetn),
    .active(sync_window),
    .tick(sync_in.tick),
    .serviced(sync_in.serviced),
    .thresh(thresh_r),
    .count(miss_count),
    .over(miss_over)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sticky error flags

  logic pll_err_r;
  logic sync_err_r;
  logic [15:0] al_code_r;

  // a held flag re-fires only when a clear lands while the cause still stands
  wire pll_set = pll_window && phase_lock_lost && (!pll_err_r || alarm_clear);
  wire sync_set = sync_window && miss_over && (!sync_err_r || alarm_clear);
  wire any_err = pll_err_r || sync_err_r;

  // detection beats a clear landing in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pll_err_r <= 1'b0;
      sync_err_r <= 1'b0;
    end
    else
    begin
      pll_err_r <= pll_set || (pll_err_r && !alarm_clear);
      sync_err_r <= sync_set || (sync_err_r && !alarm_clear);
    end
  end

  // phase lock takes priority when both fire together
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      al_code_r <= SLM_AL_NONE;
    else if (pll_set)
      al_code_r <= SLM_AL_PHASE_LOCK;
    else if (sync_set)
      al_code_r <= SLM_AL_SYNC_SIGNAL;
    else if (alarm_clear)
      al_code_r <= SLM_AL_NONE;
  end

  ////////////////////////////////////////////////////////////////////////////
  // state machine

  // going to op is refused while an error is still standing
  always_comb
  begin
    esm_nxt = esm_r;
    if (pll_set && (in_op || in_safeop))
      esm_nxt = SLM_ST_SAFEOP;
    else if (sync_set)
      esm_nxt = SLM_ST_SAFEOP;
    else if (wr_esm)
    begin
      if (!(esm_from(pwdata[1:0]) == SLM_ST_OP && any_err))
        esm_nxt = esm_from(pwdata[1:0]);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      esm_r <= SLM_ST_INIT;
    else
      esm_r <= esm_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status and mask

  logic [1:0] istat_r;
  wire [1:0] ev = {sync_set, pll_set};
  wire [1:0] w1c = wr_istat ? pwdata[1:0] : 2'b00;

  // set wins over a write-one clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      istat_r <= 2'b00;
    else
      istat_r <= ev | (istat_r & ~w1c);
  end

  logic irq_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_r <= 1'b0;
    else
      irq_r <= |((ev | (istat_r & ~w1c)) & imask_r);
  end

  ////////////////////////////////////////////////////////////////////////////
  // single flash indicator

  logic [27:0] flash_cnt_r;
  logic flash_on_r;
  localparam logic [27:0] ON_LAST = 28'(FLASH_ON_CYC - 1);
  localparam logic [27:0] OFF_LAST = 28'(FLASH_OFF_CYC - 1);
  wire flash_wrap = flash_on_r ? (flash_cnt_r == ON_LAST) : (flash_cnt_r == OFF_LAST);

  // one on pulse then a long dark gap, restarting when an error follows an error-free cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flash_cnt_r <= '0;
      flash_on_r <= 1'b0;
    end
    else if (!any_err)
    begin
      flash_cnt_r <= '0;
      flash_on_r <= 1'b1;
    end
    else if (flash_wrap)
    begin
      flash_cnt_r <= '0;
      flash_on_r <= !flash_on_r;
    end
    else
      flash_cnt_r <= flash_cnt_r + 28'h000_0001;
  end

  logic led_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      led_r <= 1'b0;
    else
      led_r <= any_err && flash_on_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data, captured in the setup phase

  wire [31:0] status_word = {
    {(32 - SLM_ST_CNT_LSB - SLM_MISS_W){1'b0}},
    miss_count,
    3'b000,
    sync_in.done,
    sync_err_r,
    pll_err_r,
    esm_code(esm_r)
  };

  wire [31:0] rd_mux =
    hit_ctrl ? {28'h000_0000, 1'b0, cfg_r.op_only, cfg_r.mode} :
    hit_thresh ? {28'h000_0000, thresh_r} :
    hit_status ? status_word :
    hit_alcode ? {16'h0000, al_code_r} :
    hit_istat ? {30'h0000_0000, istat_r} :
    hit_imask ? {30'h0000_0000, imask_r} :
    hit_esm ? {30'h0000_0000, esm_code(esm_r)} :
    32'h0000_0000;

  logic [31:0] prdata_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_r <= 32'h0000_0000;
    else if (setup && !pwrite)
      prdata_r <= rd_mux;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign prdata = prdata_r;
  assign esm_state = esm_r;
  assign al_status_code = al_code_r;
  assign phase_lock_error_code = pll_err_r;
  assign sync_signal_error_code = sync_err_r;
  assign err_led = led_r;
  assign irq = irq_r;
endmodule : slm_monitor

// File: rtl/slm_pkg.sv
// package: register map, field layout, codes and timing for the sync loss monitor
package slm_pkg;
  // register byte offsets
  localparam logic [7:0] SLM_OFS_CTRL = 8'h00;
  localparam logic [7:0] SLM_OFS_THRESH = 8'h04;
  localparam logic [7:0] SLM_OFS_STATUS = 8'h08;
  localparam logic [7:0] SLM_OFS_ALCODE = 8'h0C;
  localparam logic [7:0] SLM_OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] SLM_OFS_IRQ_MASK = 8'h14;
  localparam logic [7:0] SLM_OFS_ESM_REQ = 8'h18;
  // control field positions
  localparam int SLM_CTRL_MODE_LSB = 0;
  localparam int SLM_CTRL_OP_ONLY_BIT = 2;
  localparam int SLM_CTRL_CLEAR_BIT = 3;
  // status field positions
  localparam int SLM_ST_ESM_LSB = 0;
  localparam int SLM_ST_PLL_BIT = 2;
  localparam int SLM_ST_SYNC_BIT = 3;
  localparam int SLM_ST_DONE_BIT = 4;
  localparam int SLM_ST_CNT_LSB = 8;
  // interrupt bit positions
  localparam int SLM_IRQ_PLL_BIT = 0;
  localparam int SLM_IRQ_SYNC_BIT = 1;
  // reset values
  localparam logic [3:0] SLM_THRESH_RST = 4'h0;
  localparam logic [1:0] SLM_IRQ_MASK_RST = 2'b00;
  // synchronous mode codes
  localparam logic [1:0] SLM_MODE_FREERUN = 2'h0;
  localparam logic [1:0] SLM_MODE_DC = 2'h1;
  localparam logic [1:0] SLM_MODE_SM2 = 2'h2;
  // state machine codes as seen by software
  localparam logic [1:0] SLM_ESM_INIT = 2'h0;
  localparam logic [1:0] SLM_ESM_PREOP = 2'h1;
  localparam logic [1:0] SLM_ESM_SAFEOP = 2'h2;
  localparam logic [1:0] SLM_ESM_OP = 2'h3;
  // status codes
  localparam logic [15:0] SLM_AL_NONE = 16'h0000;
  localparam logic [15:0] SLM_AL_PHASE_LOCK = 16'h0032;
  localparam logic [15:0] SLM_AL_SYNC_SIGNAL = 16'h002C;
  // indicator timing
  localparam int SLM_CLK_MHZ = 250;
  localparam int SLM_FLASH_ON_MS = 200;
  localparam int SLM_FLASH_OFF_MS = 1000;
  localparam int SLM_FLASH_ON_CYC = SLM_FLASH_ON_MS * SLM_CLK_MHZ * 1000;
  localparam int SLM_FLASH_OFF_CYC = SLM_FLASH_OFF_MS * SLM_CLK_MHZ * 1000;
  // missed interrupt counter width
  localparam int SLM_MISS_W = 5;

  typedef enum logic [1:0] {
    SLM_ST_INIT,
    SLM_ST_PREOP,
    SLM_ST_SAFEOP,
    SLM_ST_OP
  } slm_esm_type;

  typedef struct packed {
    logic op_only;
    logic [1:0] mode;
  } slm_cfg_type;

  typedef struct packed {
    logic tick;
    logic serviced;
    logic done;
  } slm_sync_type;
endpackage : slm_pkg

// File: verification/slm_monitor_props.sv
// checker: port timing of the sync loss monitor
`timescale 1ns/1ps
module slm_monitor_props #(
  parameter int FLASH_ON_CYC = slm_pkg::SLM_FLASH_ON_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic phase_lock_lost,
  input wire slm_pkg::slm_sync_type sync_in,
  input wire slm_pkg::slm_esm_type esm_state,
  input wire logic [15:0] al_status_code,
  input wire logic phase_lock_error_code,
  input wire logic sync_signal_error_code,
  input wire logic err_led,
  input wire logic irq
);
  import slm_pkg::*;
  logic [1:0] mode_r;
  logic op_only_r;
  int led_cnt_r;
  logic wr_ctrl;
  logic clr;
  logic any_err;
  logic pll_win;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // shadow of the control bits, seen from bus writes
  assign wr_ctrl = psel && penable && pwrite && (paddr == SLM_OFS_CTRL);
  assign clr = wr_ctrl && pwdata[SLM_CTRL_CLEAR_BIT];
  assign any_err = phase_lock_error_code || sync_signal_error_code;
  assign pll_win = (mode_r == SLM_MODE_DC || mode_r == SLM_MODE_SM2) &&
    (esm_state == SLM_ST_SAFEOP || esm_state == SLM_ST_OP);
  // control shadow and length of the current led on phase
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      mode_r <= 2'h0;
      op_only_r <= 1'b0;
      led_cnt_r <= 0;
    end
    else
    begin
      if (wr_ctrl)
      begin
        mode_r <= pwdata[1:0];
        op_only_r <= pwdata[SLM_CTRL_OP_ONLY_BIT];
      end
      led_cnt_r <= err_led ? led_cnt_r + 1 : 0;
    end
  ////////////////////////////////////////
  pll_set_a: assert property (pll_win && phase_lock_lost |=> phase_lock_error_code &&
    al_status_code == SLM_AL_PHASE_LOCK && esm_state == SLM_ST_SAFEOP) else $error("lock error not raised");
  pll_hold_a: assert property (phase_lock_error_code && !clr |=> phase_lock_error_code)
    else $error("lock error dropped");
  pll_clear_a: assert property (clr && !phase_lock_lost |=> !phase_lock_error_code)
    else $error("lock error not cleared");
  sync_code_a: assert property ($rose(sync_signal_error_code) && !phase_lock_error_code |->
    al_status_code == SLM_AL_SYNC_SIGNAL && esm_state == SLM_ST_SAFEOP) else $error("sync error code");
  free_run_a: assert property (mode_r == SLM_MODE_FREERUN |=>
    !$rose(sync_signal_error_code) && !$rose(phase_lock_error_code)) else $error("error in free run");
  op_only_a: assert property (op_only_r && esm_state != SLM_ST_OP |=>
    !$rose(sync_signal_error_code)) else $error("sync error outside op");
  led_idle_a: assert property (!any_err |=> !err_led) else $error("led lit without error");
  led_on_a: assert property (err_led |-> led_cnt_r < FLASH_ON_CYC) else $error("led on too long");
  pll_c: cover property ($rose(phase_lock_error_code));
  sync_c: cover property ($rose(sync_signal_error_code));
  led_c: cover property ($fell(err_led) && any_err);
endmodule : slm_monitor_props
bind slm_monitor slm_monitor_props #(.FLASH_ON_CYC(FLASH_ON_CYC)) u_props (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .phase_lock_lost, .sync_in,
  .esm_state, .al_status_code, .phase_lock_error_code, .sync_signal_error_code, .err_led, .irq);

// File: verification/slm_sync_src.sv
// model of the far side: sync slot ticks, servicing and lock loss
`timescale 1ns/1ps
module slm_sync_src (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic miss,
  input wire logic lose,
  output slm_pkg::slm_sync_type sync_in,
  output logic phase_lock_lost
);
  import slm_pkg::*;
  logic [1:0] slot_r;
  // one slot per four cycles; ticks only once sync is enabled
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      slot_r <= 2'h0;
      sync_in <= '0;
    end
    else
    begin
      slot_r <= slot_r + 2'h1;
      sync_in.tick <= run && (slot_r == 2'h3);
      sync_in.serviced <= run && (slot_r == 2'h3) && !miss;
      sync_in.done <= run;
    end
  // lock loss only on command, as after a late offset setup
  assign phase_lock_lost = lose;
endmodule : slm_sync_src

// File: verification/sync_loss_error_monitor_tb.sv
// testbench: bus access, error detection and recovery of the sync loss monitor
`timescale 1ns/1ps
module sync_loss_error_monitor_tb;
  import slm_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, phase_lock_lost, phase_lock_error_code, sync_signal_error_code, err_led, irq;
  logic run = 0, miss = 0, lose = 0, err_seen;
  slm_sync_type sync_in;
  slm_esm_type esm_state;
  logic [15:0] al_status_code;
  logic [31:0] led_on;
  int failures = 0, checks_done = 0;
  // short flash counts keep the run brief
  slm_monitor #(.FLASH_ON_CYC(4), .FLASH_OFF_CYC(8)) DUT (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .phase_lock_lost, .sync_in, .esm_state,
    .al_status_code, .phase_lock_error_code, .sync_signal_error_code, .err_led, .irq);
  slm_sync_src u_src (.pclk, .presetn, .run, .miss, .lose, .sync_in, .phase_lock_lost);
  initial
    forever #2 pclk = ~pclk;
  ////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // one apb transfer; an idle edge after it avoids double drives
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0000_0000);
    chk(what, exp, rd);
  endtask : rdchk
  task automatic clear_all;
    apb(1'b1, SLM_OFS_CTRL, 32'h0000_0009);
    apb(1'b1, SLM_OFS_IRQ_STAT, 32'h0000_0003);
  endtask : clear_all
  task automatic end_of_test;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_of_test
  // hang guard, far beyond the few hundred cycles needed
  initial
  begin
    #40000;
    failures++;
    end_of_test();
  end
  ////////////////////////////////////////
  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdchk(SLM_OFS_STATUS, 32'h0000_0000, "status");
    rdchk(SLM_OFS_THRESH, {28'h000_0000, SLM_THRESH_RST}, "thresh");
    rdchk(8'h1C, 32'h0000_0000, "unmapped");
    chk("slverr", 32'h0000_0001, err_seen);
    apb(1'b1, SLM_OFS_THRESH, 32'h0000_0003);
    apb(1'b1, SLM_OFS_IRQ_MASK, 32'h0000_0003);
    apb(1'b1, SLM_OFS_CTRL, 32'h0000_0001);
    for (int s = 1; s < 4; s++)
      apb(1'b1, SLM_OFS_ESM_REQ, s);
    run <= 1'b1;
    // at most three misses, then serviced again
    miss <= 1'b1;
    repeat (9) @(posedge pclk);
    miss <= 1'b0;
    repeat (20) @(posedge pclk);
    rdchk(SLM_OFS_STATUS, 32'h0000_0013, "status");
    miss <= 1'b1;
    repeat (40) @(posedge pclk);
    miss <= 1'b0;
    chk("sync flag", 32'h0000_0001, sync_signal_error_code);
    chk("code", 32'h0000_002C, al_status_code);
    chk("state", SLM_ST_SAFEOP, esm_state);
    chk("irq", 32'h0000_0001, irq);
    repeat (8) @(posedge pclk);
    clear_all();
    chk("cleared", 32'h0000_0000, {irq, sync_signal_error_code, al_status_code});
    // op-only set: safe state is not watched, then it is
    apb(1'b1, SLM_OFS_CTRL, 32'h0000_0005);
    miss <= 1'b1;
    repeat (40) @(posedge pclk);
    chk("op only", 32'h0000_0000, sync_signal_error_code);
    apb(1'b1, SLM_OFS_CTRL, 32'h0000_0001);
    repeat (40) @(posedge pclk);
    chk("safe watch", 32'h0000_0001, sync_signal_error_code);
    miss <= 1'b0;
    repeat (8) @(posedge pclk);
    clear_all();
    // free run: neither error may appear
    apb(1'b1, SLM_OFS_CTRL, 32'h0000_0000);
    apb(1'b1, SLM_OFS_ESM_REQ, 32'h0000_0003);
    miss <= 1'b1;
    lose <= 1'b1;
    repeat (40) @(posedge pclk);
    chk("free sync", 32'h0000_0000, sync_signal_error_code);
    chk("free lock", 32'h0000_0000, phase_lock_error_code);
    chk("free state", SLM_ST_OP, esm_state);
    miss <= 1'b0;
    lose <= 1'b0;
    // sm2 with op-only set: lock loss is still watched in op
    apb(1'b1, SLM_OFS_CTRL, 32'h0000_0006);
    repeat (8) @(posedge pclk);
    lose <= 1'b1;
    repeat (3) @(posedge pclk);
    lose <= 1'b0;
    chk("lock flag", 32'h0000_0001, phase_lock_error_code);
    chk("lock code", 32'h0000_0032, al_status_code);
    chk("lock state", SLM_ST_SAFEOP, esm_state);
    // any twelve cycles of a standing error hold one four-cycle flash
    led_on = 32'h0000_0000;
    repeat (12)
    begin
      @(posedge pclk);
      led_on = led_on + {31'h0000_0000, err_led};
    end
    chk("led flash", 32'h0000_0004, led_on);
    repeat (18) @(posedge pclk);
    clear_all();
    chk("lock clear", 32'h0000_0000, {err_led, phase_lock_error_code, al_status_code});
    end_of_test();
  end
endmodule : sync_loss_error_monitor_tb
